// ---- coulomb_count.sv ----
`timescale 1ns/10ps
// What this block does
// (R1) Negative pulses count discharge, run discharge timer.
// (R2) Timers advance 1.138 per second normally.
// (R3) Positive pulses count charge, run charge timer.
// (R4) Timer wrap sets slow flag, 1/256 rate.
// (R5) Timer periods 0.8789 s, or 225 s slow.
// (R6) Self-discharge hourly at 25C, doubling per 10C.
// (R7) Compensation adds one count per offset period.
// (R8) Sleep command waits for activity below threshold.
// (R9) Threshold code zero sleeps immediately.
// (R10) Asleep, only self-discharge and temperature update.
// (R11) Any serial line edge ends sleep.
// (R12) Host should save registers before sleeping.
// (R13) Request bit or command starts calibration.
// (R14) Calibration completion drives good bit to zero.
// (R15) Offset is interval between like pulses.
// (R16) Opposite second pulse restarts calibration.
// (R17) Calibration timeout adopts default 4.29 uV offset.
// (R18) Isolation bit shorts sense input to ground.
// (R19) Writing clear bit zeroes that counter.
// (R20) Clear bits return to zero by themselves.
// (R21) Clearing a timer clears its slow flag.
// (R22) Temperature reported as 9-bit kelvin value.
// (R23) No pulse, no counting; one side per pulse.
module coulomb_count
  import coulomb_pkg::*;
#(
  parameter int unsigned TIMER_TICK_CYCLES = TIMER_TICK_CYC,
  parameter int unsigned CAL_LSB_CYCLES    = CAL_LSB_CYC
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  // Register access from the serial-line engine
  input  wire reg_req_s   i_reg_req,
  output logic [7:0]      o_reg_rdata,
  output logic            o_reg_rvalid,
  // Converter and analog front end
  input  wire logic       i_pulse_pos,
  input  wire logic       i_pulse_neg,
  input  wire logic       i_below_wake,
  input  wire logic [8:0] i_temp_kelvin,
  output logic [2:0]      o_wake_threshold_sel,
  output logic            o_sense_short,
  output logic            o_regulator_off,
  // Serial line level and power state
  input  wire logic       i_line,
  output logic            o_asleep
);

  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) rst_sync_q <= 2'b00;
    else          rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Pin inputs pass two flops; the third stage only serves edge detection.
  logic [2:0] pos_s_q, neg_s_q, line_s_q;
  logic [1:0] below_s_q;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_s_q   <= 3'h0;
      neg_s_q   <= 3'h0;
      // The line idles high, so its stages start high and no false edge follows reset.
      line_s_q  <= 3'h7;
      below_s_q <= 2'h0;
    end else begin
      pos_s_q   <= {pos_s_q[1:0], i_pulse_pos};
      neg_s_q   <= {neg_s_q[1:0], i_pulse_neg};
      line_s_q  <= {line_s_q[1:0], i_line};
      below_s_q <= {below_s_q[0], i_below_wake};
    end
  end

  logic pos_edge, neg_edge, line_edge, below;
  assign pos_edge  = pos_s_q[1] & ~pos_s_q[2];
  assign neg_edge  = neg_s_q[1] & ~neg_s_q[2];
  assign line_edge = line_s_q[1] ^ line_s_q[2]; // R11
  assign below     = below_s_q[1];

  // Register state.
  pwr_e        pwr_q;
  cal_e        cal_q;
  logic        isolate_q, reg_off_q, mode_b0_q, comp_en_q, cal_req_q, cal_good_q;
  logic        polarity_q, cal_pd_q, first_pol_q;
  logic [2:0]  woe_q;
  logic [19:0] offset_q, cal_tmr_q, comp_cnt_q;
  logic [CLR_WIDTH-1:0] clr_q;
  logic [8:0]  temp_q;
  logic [15:0] acc_q [2];
  logic [15:0] tmr_q [2];
  logic [1:0]  slow_q, seen_q;
  logic [7:0]  sub_q [2];
  logic [15:0] self_q;
  logic [7:0]  sd_sub_q;
  logic [6:0]  sd_frac_q;
  logic [31:0] tick_cnt_q, lsb_cnt_q;

  logic awake, tick, lsb_tick;
  assign awake    = (pwr_q != PWR_SLEEP); // R10
  assign tick     = (tick_cnt_q == TIMER_TICK_CYCLES - 1);
  assign lsb_tick = (lsb_cnt_q == CAL_LSB_CYCLES - 1);

  // The timebase keeps running in sleep: it stands for the brief periodic wakes.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0;
      lsb_cnt_q  <= 32'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      lsb_cnt_q  <= lsb_tick ? 32'h0 : lsb_cnt_q + 32'h1;
    end
  end

  // Register decode.
  logic wr_nv_cmd, wr_clear, wr_mode, wr_cal_h, wr_off_m, wr_off_l;
  logic sleep_cmd, cal_pd_cmd, cal_start;
  assign wr_nv_cmd  = i_reg_req.wr && (i_reg_req.addr == ADDR_NV_CMD);
  assign wr_clear   = i_reg_req.wr && (i_reg_req.addr == ADDR_CLEAR);
  assign wr_mode    = i_reg_req.wr && (i_reg_req.addr == ADDR_MODE_WAKE);
  assign wr_cal_h   = i_reg_req.wr && (i_reg_req.addr == ADDR_CAL_OFFS_H);
  assign wr_off_m   = i_reg_req.wr && (i_reg_req.addr == ADDR_OFFSET_M);
  assign wr_off_l   = i_reg_req.wr && (i_reg_req.addr == ADDR_OFFSET_L);
  assign cal_pd_cmd = wr_nv_cmd && (i_reg_req.wdata == CMD_CAL_POWER_DOWN);
  assign cal_start  = cal_pd_cmd || (wr_cal_h && i_reg_req.wdata[CAL_REQUEST]); // R13

  // Calibration.
  logic cal_measuring, cal_timeout, cal_pulse, cal_same, cal_done, cal_done_pd;
  assign cal_measuring = (cal_q == CAL_FIRST) || (cal_q == CAL_SECOND);
  assign cal_timeout   = cal_measuring && (cal_tmr_q >= CAL_TIMEOUT_LSB); // R17
  assign cal_pulse     = pos_edge ^ neg_edge;
  assign cal_same      = (pos_edge == first_pol_q);
  assign cal_done      = cal_timeout ||
                         ((cal_q == CAL_SECOND) && !cal_timeout && cal_pulse && cal_same);
  assign cal_done_pd   = cal_done && cal_pd_q;
  assign sleep_cmd     = (wr_nv_cmd && (i_reg_req.wdata == CMD_POWER_DOWN)) || cal_done_pd;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_q       <= CAL_IDLE;
      cal_tmr_q   <= 20'h0;
      first_pol_q <= 1'b0;
      cal_pd_q    <= 1'b0;
    end else begin
      unique case (cal_q)
        CAL_IDLE: if (cal_start) begin
          cal_q    <= CAL_ARM;
          cal_pd_q <= cal_pd_cmd;
        end
        CAL_ARM: if (woe_q == 3'h0 || below) begin // R13
          cal_q     <= CAL_FIRST;
          cal_tmr_q <= 20'h0;
        end
        CAL_FIRST: if (cal_timeout) begin
          cal_q <= CAL_IDLE;
        end else if (cal_pulse) begin
          cal_q       <= CAL_SECOND;
          first_pol_q <= pos_edge;
          cal_tmr_q   <= 20'h0;
        end else if (lsb_tick) begin
          cal_tmr_q <= cal_tmr_q + 20'h1;
        end
        CAL_SECOND: if (cal_done) begin
          cal_q <= CAL_IDLE;
        end else if (cal_pulse) begin
          cal_q     <= CAL_FIRST; // R16
          cal_tmr_q <= 20'h0;
        end else if (lsb_tick) begin
          cal_tmr_q <= cal_tmr_q + 20'h1; // R15
        end
      endcase
    end
  end

  // Calibration and offset register; hardware completion wins over a host write.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      comp_en_q  <= 1'b0;
      cal_req_q  <= 1'b0;
      cal_good_q <= 1'b1;
      polarity_q <= 1'b0;
      offset_q   <= 20'h0;
    end else if (cal_done) begin
      cal_req_q  <= 1'b0;
      cal_good_q <= 1'b0; // R14
      polarity_q <= cal_timeout ? polarity_q : first_pol_q;
      offset_q   <= cal_timeout ? DEFAULT_OFFSET_LSB : cal_tmr_q; // R15 R17
    end else begin
      if (wr_cal_h) begin
        comp_en_q      <= i_reg_req.wdata[CAL_COMP_EN];
        cal_good_q     <= i_reg_req.wdata[CAL_GOOD];
        polarity_q     <= i_reg_req.wdata[CAL_POLARITY];
        offset_q[19:16] <= i_reg_req.wdata[3:0];
      end
      if (cal_start) cal_req_q <= 1'b1; // R13
      if (wr_off_m) offset_q[15:8] <= i_reg_req.wdata;
      if (wr_off_l) offset_q[7:0] <= i_reg_req.wdata;
    end
  end

  // Offset compensation.
  logic comp_run, comp_fire;
  logic [1:0] comp_add;
  assign comp_run  = awake && comp_en_q && !cal_good_q && (offset_q != 20'h0);
  assign comp_fire = comp_run && lsb_tick && (comp_cnt_q >= offset_q - 20'h1); // R7
  assign comp_add  = {comp_fire && polarity_q, comp_fire && !polarity_q};

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n)          comp_cnt_q <= 20'h0;
    else if (!comp_run)  comp_cnt_q <= 20'h0;
    else if (comp_fire)  comp_cnt_q <= 20'h0;
    else if (lsb_tick)   comp_cnt_q <= comp_cnt_q + 20'h1;
  end

  // Sleep control.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_RUN;
    end else begin
      unique case (pwr_q)
        PWR_RUN:   if (sleep_cmd) pwr_q <= PWR_PEND;
        PWR_PEND:  if (line_edge) pwr_q <= PWR_RUN; // R11
                   else if (woe_q == 3'h0 || below) pwr_q <= PWR_SLEEP; // R8 R9
        PWR_SLEEP: if (line_edge) pwr_q <= PWR_RUN; // R11
        default:   pwr_q <= PWR_RUN;
      endcase
    end
  end

  // Mode register, clear register and temperature sample.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      isolate_q <= 1'b0;
      reg_off_q <= 1'b0;
      woe_q     <= 3'h0;
      mode_b0_q <= 1'b0;
      clr_q     <= '0;
      temp_q    <= 9'h0;
    end else begin
      if (wr_mode) begin
        isolate_q <= i_reg_req.wdata[MODE_ISOLATE]; // R18
        reg_off_q <= i_reg_req.wdata[MODE_REG_OFF];
        woe_q     <= i_reg_req.wdata[3:1];
        mode_b0_q <= i_reg_req.wdata[0];
      end
      // Each set bit acts for one cycle, then falls back to zero by itself.
      clr_q <= wr_clear ? i_reg_req.wdata[CLR_WIDTH-1:0] : '0; // R19 R20
      if (tick) temp_q <= i_temp_kelvin; // R10 R22
    end
  end

  // Accumulators and elapsed-time counters; index 0 is discharge, 1 is charge.
  logic [1:0] act, clr_acc, clr_tmr, step;
  assign act     = {awake && pos_edge && !neg_edge, awake && neg_edge && !pos_edge}; // R23
  assign clr_acc = {clr_q[CLR_CHG_ACC], clr_q[CLR_DIS_ACC]};
  assign clr_tmr = {clr_q[CLR_CHG_TMR], clr_q[CLR_DIS_TMR]};

  for (genvar g = 0; g < 2; g++) begin : g_side
    // A timer only runs for a side that saw at least one pulse in its period.
    assign step[g] = awake && tick && (!slow_q[g] || sub_q[g] == SLOW_DIV_LAST); // R2 R5

    always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
        acc_q[g] <= 16'h0;
      end else if (clr_acc[g]) begin
        acc_q[g] <= 16'h0; // R19
      end else begin
        acc_q[g] <= acc_q[g] + 16'(act[g]) + 16'(comp_add[g]); // R1 R3 R7
      end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
        tmr_q[g]  <= 16'h0;
        slow_q[g] <= 1'b0;
        sub_q[g]  <= 8'h0;
        seen_q[g] <= 1'b0;
      end else if (clr_tmr[g]) begin
        tmr_q[g]  <= 16'h0; // R19
        slow_q[g] <= 1'b0; // R21
        sub_q[g]  <= 8'h0;
        seen_q[g] <= 1'b0;
      end else begin
        if (awake && tick && slow_q[g]) sub_q[g] <= sub_q[g] + 8'h1; // R5
        if (step[g]) begin
          seen_q[g] <= act[g];
          if (seen_q[g]) begin
            tmr_q[g] <= tmr_q[g] + 16'h1; // R1 R3 R23
            if (tmr_q[g] == 16'hffff) slow_q[g] <= 1'b1; // R4
          end
        end else if (act[g]) begin
          seen_q[g] <= 1'b1;
        end
      end
    end
  end

  // Self-discharge: a fraction of 1/128 count per sixteenth hour, scaled by band.
  logic [2:0] sd_band;
  logic [7:0] sd_sum;
  logic       sd_tick;
  always_comb begin
    sd_band = 3'h0;
    for (int b = 0; b < SD_BANDS; b++) begin
      if (temp_q >= SD_BAND_BASE_K + 9'(b) * SD_BAND_STEP_K) sd_band = sd_band + 3'h1;
    end
  end
  assign sd_tick = tick && (sd_sub_q == SLOW_DIV_LAST);
  assign sd_sum  = {1'b0, sd_frac_q} + (8'h1 << sd_band); // R6

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      self_q    <= 16'h0;
      sd_sub_q  <= 8'h0;
      sd_frac_q <= 7'h0;
    end else begin
      if (tick) sd_sub_q <= sd_sub_q + 8'h1;
      if (clr_q[CLR_SELF]) begin
        self_q    <= 16'h0; // R19
        sd_frac_q <= 7'h0;
      end else if (sd_tick) begin
        sd_frac_q <= sd_sum[6:0];
        self_q    <= self_q + 16'(sd_sum[7]); // R6 R10
      end
    end
  end

  // Read selection; unmapped addresses read as zero.
  logic [7:0] mode_rd, cal_rd, rd_mux;
  logic [6:0] ra;
  assign ra      = i_reg_req.addr;
  assign mode_rd = {isolate_q, reg_off_q, slow_q[1], slow_q[0], woe_q, mode_b0_q};
  assign cal_rd  = {comp_en_q, cal_req_q, cal_good_q, polarity_q, offset_q[19:16]};
  assign rd_mux  = (ra == ADDR_TEMP_LOW)   ? temp_q[7:0] : // R22
                   (ra == ADDR_TEMP_HIGH)  ? {7'h0, temp_q[8]} :
                   (ra == ADDR_CLEAR)      ? {3'h0, clr_q} :
                   (ra == ADDR_MODE_WAKE)  ? mode_rd :
                   (ra == ADDR_CHG_TMR_L)  ? tmr_q[1][7:0] :
                   (ra == ADDR_CHG_TMR_H)  ? tmr_q[1][15:8] :
                   (ra == ADDR_DIS_TMR_L)  ? tmr_q[0][7:0] :
                   (ra == ADDR_DIS_TMR_H)  ? tmr_q[0][15:8] :
                   (ra == ADDR_SELF_L)     ? self_q[7:0] :
                   (ra == ADDR_SELF_H)     ? self_q[15:8] :
                   (ra == ADDR_CHG_ACC_L)  ? acc_q[1][7:0] :
                   (ra == ADDR_CHG_ACC_H)  ? acc_q[1][15:8] :
                   (ra == ADDR_DIS_ACC_L)  ? acc_q[0][7:0] :
                   (ra == ADDR_DIS_ACC_H)  ? acc_q[0][15:8] :
                   (ra == ADDR_OFFSET_L)   ? offset_q[7:0] :
                   (ra == ADDR_OFFSET_M)   ? offset_q[15:8] :
                   (ra == ADDR_CAL_OFFS_H) ? cal_rd : 8'h00;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata          <= 8'h00;
      o_reg_rvalid         <= 1'b0;
      o_wake_threshold_sel <= 3'h0;
      o_sense_short        <= 1'b0;
      o_regulator_off      <= 1'b0;
      o_asleep             <= 1'b0;
    end else begin
      if (i_reg_req.rd) o_reg_rdata <= rd_mux;
      o_reg_rvalid         <= i_reg_req.rd;
      o_wake_threshold_sel <= woe_q;
      o_sense_short        <= isolate_q; // R18
      o_regulator_off      <= reg_off_q;
      o_asleep             <= !awake;
    end
  end

endmodule // coulomb_count

// ---- coulomb_pkg.sv ----
package coulomb_pkg;

  // Clock and time figures.
  localparam longint CLOCK_PERIOD_NS   = 64'd5;
  localparam longint TIMER_TICK_NS     = 64'd878_900_000;     // 0.8789 s
  localparam longint CAL_LSB_NS        = 64'd9_760_000;       // 9.76 ms
  localparam longint CAL_TIMEOUT_MS    = 64'd1_278_000;       // 21.3 minutes
  localparam int unsigned TIMER_TICK_CYC = int'(TIMER_TICK_NS / CLOCK_PERIOD_NS);
  localparam int unsigned CAL_LSB_CYC    = int'(CAL_LSB_NS / CLOCK_PERIOD_NS);
  localparam logic [19:0] CAL_TIMEOUT_LSB = 20'(CAL_TIMEOUT_MS * 64'd1_000_000 / CAL_LSB_NS);

  // Default offset of 4.29 uV, as a compensation period of 3.05 uVh / 4.29 uV.
  localparam longint CHARGE_QUANTUM_NUV = 64'd3050;  // 3.05 uVh per count
  localparam longint DEFAULT_OFFSET_NUV = 64'd4290;  // 4.29 uV
  localparam logic [19:0] DEFAULT_OFFSET_LSB = 20'((CHARGE_QUANTUM_NUV * 64'd3600 *
    64'd1_000_000_000) / (DEFAULT_OFFSET_NUV * CAL_LSB_NS));

  // Slow elapsed-time rate is 1/256 of normal; 256 ticks also make one sixteenth hour.
  localparam logic [7:0] SLOW_DIV_LAST = 8'hff;

  // Self-discharge temperature bands in kelvin.
  localparam logic [8:0] SD_BAND_BASE_K = 9'h116;  // 278 K, 5 C
  localparam logic [8:0] SD_BAND_STEP_K = 9'h00a;  // 10 K
  localparam int unsigned SD_BANDS      = 6;

  // Register addresses.
  localparam logic [6:0] ADDR_TEMP_LOW   = 7'h60;
  localparam logic [6:0] ADDR_TEMP_HIGH  = 7'h61;
  localparam logic [6:0] ADDR_NV_CMD     = 7'h62;
  localparam logic [6:0] ADDR_CLEAR      = 7'h63;
  localparam logic [6:0] ADDR_MODE_WAKE  = 7'h64;
  localparam logic [6:0] ADDR_CHG_TMR_L  = 7'h65;
  localparam logic [6:0] ADDR_CHG_TMR_H  = 7'h66;
  localparam logic [6:0] ADDR_DIS_TMR_L  = 7'h67;
  localparam logic [6:0] ADDR_DIS_TMR_H  = 7'h68;
  localparam logic [6:0] ADDR_SELF_L     = 7'h69;
  localparam logic [6:0] ADDR_SELF_H     = 7'h6a;
  localparam logic [6:0] ADDR_CHG_ACC_L  = 7'h6b;
  localparam logic [6:0] ADDR_CHG_ACC_H  = 7'h6c;
  localparam logic [6:0] ADDR_DIS_ACC_L  = 7'h6d;
  localparam logic [6:0] ADDR_DIS_ACC_H  = 7'h6e;
  localparam logic [6:0] ADDR_OFFSET_L   = 7'h75;
  localparam logic [6:0] ADDR_OFFSET_M   = 7'h76;
  localparam logic [6:0] ADDR_CAL_OFFS_H = 7'h77;

  // Commands written to the nonvolatile command register.
  localparam logic [7:0] CMD_POWER_DOWN     = 8'hf6;
  localparam logic [7:0] CMD_CAL_POWER_DOWN = 8'hf7;

  // Clear register bit positions.
  localparam int unsigned CLR_DIS_ACC = 0;
  localparam int unsigned CLR_CHG_ACC = 1;
  localparam int unsigned CLR_SELF    = 2;
  localparam int unsigned CLR_DIS_TMR = 3;
  localparam int unsigned CLR_CHG_TMR = 4;
  localparam int unsigned CLR_WIDTH   = 5;

  // Mode and calibration register bit positions.
  localparam int unsigned MODE_ISOLATE   = 7;
  localparam int unsigned MODE_REG_OFF   = 6;
  localparam int unsigned MODE_CHG_SLOW  = 5;
  localparam int unsigned MODE_DIS_SLOW  = 4;
  localparam int unsigned CAL_COMP_EN    = 7;
  localparam int unsigned CAL_REQUEST    = 6;
  localparam int unsigned CAL_GOOD       = 5;
  localparam int unsigned CAL_POLARITY   = 4;

  // Request from the serial-line engine, one cycle per access.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_PEND  = 2'b01,
    PWR_SLEEP = 2'b10
  } pwr_e;

  typedef enum logic [1:0] {
    CAL_IDLE   = 2'b00,
    CAL_ARM    = 2'b01,
    CAL_FIRST  = 2'b10,
    CAL_SECOND = 2'b11
  } cal_e;

endpackage

// ---- coulomb_count_properties.sv ----
`timescale 1ns/10ps
module coulomb_count_checker
  import coulomb_pkg::*;
#(
  parameter int unsigned TIMER_TICK_CYCLES = TIMER_TICK_CYC,
  parameter int unsigned CAL_LSB_CYCLES    = CAL_LSB_CYC
) (
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  // Register path
  input wire reg_req_s   i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  // Analog side and power
  input wire logic       i_below_wake,
  input wire logic [2:0] o_wake_threshold_sel,
  input wire logic       o_sense_short,
  input wire logic       i_line,
  input wire logic       o_asleep
);
  wire logic mode_wr  = i_reg_req.wr && i_reg_req.addr == ADDR_MODE_WAKE;
  wire logic clear_wr = i_reg_req.wr && i_reg_req.addr == ADDR_CLEAR;
  wire logic sleep_wr = i_reg_req.wr && i_reg_req.addr == ADDR_NV_CMD &&
                        i_reg_req.wdata == CMD_POWER_DOWN;
  logic       line_q;
  logic [3:0] line_age_q;
  wire logic  line_edge = i_line != line_q;

  // Cycles since the serial line last moved, saturating so it never wraps back to a recent age.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_q     <= 1'b1;
      line_age_q <= 4'hf;
    end else begin
      line_q     <= i_line;
      line_age_q <= line_edge ? 4'h0 : (line_age_q == 4'hf ? 4'hf : line_age_q + 4'h1);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  isolate_follow_a: assert property (
    mode_wr |-> ##2 o_sense_short == $past(i_reg_req.wdata[MODE_ISOLATE], 2))
    else $error("isolation output does not follow the mode write");
  wake_field_a: assert property (
    mode_wr |-> ##2 o_wake_threshold_sel == $past(i_reg_req.wdata[3:1], 2))
    else $error("wake threshold select does not follow the mode write");
  zero_sleep_a: assert property (
    sleep_wr && o_wake_threshold_sel == 3'h0 |-> ##[1:6] o_asleep)
    else $error("no sleep after power down with threshold zero");
  early_sleep_a: assert property (
    (o_wake_threshold_sel != 3'h0 && !i_below_wake)[*6] |-> !$rose(o_asleep))
    else $error("sleep entered while activity above threshold");
  line_wake_a: assert property (o_asleep && line_edge |-> ##[1:5] !o_asleep)
    else $error("line edge did not end sleep");
  wake_cause_a: assert property ($fell(o_asleep) |-> line_age_q < 4'h6)
    else $error("sleep ended without a line edge");
  temp_pad_a: assert property (
    i_reg_req.rd && i_reg_req.addr == ADDR_TEMP_HIGH |=> o_reg_rdata[7:1] == 7'h00)
    else $error("temperature high register has stray bits");
  clear_done_a: assert property (
    i_reg_req.rd && i_reg_req.addr == ADDR_CLEAR && !clear_wr && !$past(clear_wr)
    |=> o_reg_rdata == 8'h00)
    else $error("clear bits did not return to zero");

  sleep_c: cover property ($rose(o_asleep));
  wake_c: cover property ($fell(o_asleep));
  clear_read_c: cover property (clear_wr ##[1:8] i_reg_req.rd);
endmodule // coulomb_count_checker

bind coulomb_count coulomb_count_checker #(
  .TIMER_TICK_CYCLES(TIMER_TICK_CYCLES),
  .CAL_LSB_CYCLES   (CAL_LSB_CYCLES)
) i_checker (
  .i_clock             (i_clock),
  .i_rst_b             (i_rst_b),
  .i_reg_req           (i_reg_req),
  .o_reg_rdata         (o_reg_rdata),
  .i_below_wake        (i_below_wake),
  .o_wake_threshold_sel(o_wake_threshold_sel),
  .o_sense_short       (o_sense_short),
  .i_line              (i_line),
  .o_asleep            (o_asleep)
);

// ---- coulomb_host_model.sv ----
`timescale 1ns/10ps
module coulomb_host_model
  import coulomb_pkg::*;
(
  // Clock
  input  wire logic i_clock,
  // Toward the block
  output reg_req_s  o_req,
  output logic      o_line
);
  initial begin
    o_req  = '0;
    o_line = 1'b1;
  end

  task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] data);
    @(posedge i_clock);
    #1;
    o_req = '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(posedge i_clock);
    #1;
    o_req = '0;
  endtask

  // Saving the volatile registers first keeps the counts if supply is lost while asleep.
  task automatic sleep_cmd();
    access(1'b1, ADDR_NV_CMD, 8'h45);
    access(1'b1, ADDR_NV_CMD, CMD_POWER_DOWN);
  endtask

  task automatic cal_request();
    // The good bit is written back high so that only completion can lower it.
    access(1'b1, ADDR_CAL_OFFS_H, 8'h60);
  endtask

  task automatic clear(input logic [7:0] mask);
    access(1'b1, ADDR_CLEAR, mask);
  endtask

  // The line idles high, so a low pulse gives a falling and then a rising edge.
  task automatic line_pulse();
    @(posedge i_clock);
    #1;
    o_line = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    o_line = 1'b1;
  endtask
endmodule // coulomb_host_model

// ---- test_coulomb_count.sv ----
`timescale 1ns/10ps
module test_coulomb_count;
  import coulomb_pkg::*;
  localparam int unsigned TICK = 20;
  localparam int unsigned LSB  = 4;
  logic        clock     = 1'b0;
  logic        rst_b     = 1'b0;
  logic        pulse_pos = 1'b0;
  logic        pulse_neg = 1'b0;
  logic        below     = 1'b0;
  logic [8:0]  temp      = 9'h12c;
  reg_req_s    req;
  logic        line;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [2:0]  wsel;
  logic        short_gnd;
  logic        reg_off;
  logic        asleep;
  int          miscompares = 0;
  int          cmp_count   = 0;
  logic [8:0]  exp_q[$];  // Bit 8 set means any nonzero byte is accepted.
  logic [15:0] chg = 16'h0;
  logic [15:0] dis = 16'h0;

  always #2.5 clock = ~clock;

  coulomb_host_model i_host (.i_clock(clock), .o_req(req), .o_line(line));

  coulomb_count #(
    .TIMER_TICK_CYCLES(TICK),
    .CAL_LSB_CYCLES   (LSB)
  ) i_dut (
    .i_clock             (clock),
    .i_rst_b             (rst_b),
    .i_reg_req           (req),
    .o_reg_rdata         (rdata),
    .o_reg_rvalid        (rvalid),
    .i_pulse_pos         (pulse_pos),
    .i_pulse_neg         (pulse_neg),
    .i_below_wake        (below),
    .i_temp_kelvin       (temp),
    .o_wake_threshold_sel(wsel),
    .o_sense_short       (short_gnd),
    .o_regulator_off     (reg_off),
    .i_line              (line),
    .o_asleep            (asleep)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge clock) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk({8'h00, rdata}, 16'hffff);
      end else if (exp_q[0][8]) begin
        chk(16'(rdata != 8'h00), 16'h0001);
        void'(exp_q.pop_front());
      end else begin
        chk({8'h00, rdata}, {7'h00, exp_q.pop_front()});
      end
    end
  end

  task automatic rd(input logic [6:0] addr, input logic [8:0] exp);
    exp_q.push_back(exp);
    i_host.access(1'b0, addr, 8'h00);
  endtask

  task automatic rd16(input logic [6:0] addr, input logic [15:0] exp);
    rd(addr, {1'b0, exp[7:0]});
    rd(addr + 7'h1, {1'b0, exp[15:8]});
  endtask

  task automatic pulse(input int side);
    @(posedge clock);
    #1;
    pulse_pos = (side != 1);
    pulse_neg = (side != 0);
    repeat (4) @(posedge clock);
    #1;
    pulse_pos = 1'b0;
    pulse_neg = 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (asleep !== lvl && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(16'(asleep), 16'(lvl));
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    summarize();
  end

  initial begin
    int s;
    void'($urandom(22735));
    temp = 9'($urandom);
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clock);
    rd(ADDR_CAL_OFFS_H, 9'h020);
    rd(7'h74, 9'h000);
    // Every pulse is followed by two ticks, so each counted pulse steps its timer once.
    for (int i = 0; i < 8; i++) begin
      s = (i < 3) ? i : int'($urandom_range(2, 0));
      pulse(s);
      repeat (2 * TICK) @(posedge clock);
      if (s == 0) chg++;
      if (s == 1) dis++;
    end
    rd16(ADDR_CHG_ACC_L, chg);
    rd16(ADDR_DIS_ACC_L, dis);
    rd16(ADDR_CHG_TMR_L, chg);
    rd16(ADDR_DIS_TMR_L, dis);
    rd(ADDR_TEMP_LOW, {1'b0, temp[7:0]});
    rd(ADDR_TEMP_HIGH, {8'h00, temp[8]});
    i_host.clear(8'h1f);
    repeat (3) @(posedge clock);
    rd(ADDR_CLEAR, 9'h000);
    rd16(ADDR_DIS_ACC_L, 16'h0000);
    rd16(ADDR_CHG_TMR_L, 16'h0000);
    rd(ADDR_MODE_WAKE, 9'h000);
    chg = 16'h0;
    i_host.access(1'b1, ADDR_MODE_WAKE, 8'hc6);
    // Mode outputs follow the register one cycle after the write lands.
    @(posedge clock);
    #1;
    chk(16'(short_gnd), 16'h0001);
    chk(16'(wsel), 16'h0003);
    chk(16'(reg_off), 16'h0001);
    rd(ADDR_MODE_WAKE, 9'h0c6);
    i_host.sleep_cmd();
    repeat (30) @(posedge clock);
    #1;
    chk(16'(asleep), 16'h0000);
    below = 1'b1;
    wait_sleep(1'b1);
    pulse(0);
    i_host.line_pulse();
    wait_sleep(1'b0);
    below = 1'b0;
    i_host.access(1'b1, ADDR_MODE_WAKE, 8'h00);
    @(posedge clock);
    #1;
    chk(16'(short_gnd), 16'h0000);
    i_host.sleep_cmd();
    wait_sleep(1'b1);
    pulse(1);
    i_host.line_pulse();
    wait_sleep(1'b0);
    rd16(ADDR_CHG_ACC_L, chg);
    rd16(ADDR_DIS_ACC_L, dis - dis);
    i_host.cal_request();
    pulse(0);
    pulse(1);
    repeat (10) @(posedge clock);
    rd(ADDR_CAL_OFFS_H, 9'h060);
    for (int i = 0; i < 3; i++) begin
      pulse(0);
      repeat (30) @(posedge clock);
    end
    rd(ADDR_CAL_OFFS_H, 9'h010);
    rd(ADDR_OFFSET_L, 9'h100);
    i_host.clear(8'h03);
    i_host.access(1'b1, ADDR_CAL_OFFS_H, 8'h90);
    repeat (300) @(posedge clock);
    rd(ADDR_CHG_ACC_L, 9'h100);
    rd16(ADDR_DIS_ACC_L, 16'h0000);
    repeat (5) @(posedge clock);
    summarize();
  end
endmodule // test_coulomb_count
